// ---- adcc_clk_div.sv ----
module adcc_clk_div
  import adcc_pkg::*;
(
  input wire logic refClk, // System clock
  input wire logic rst_n, // Sync reset
  input wire logic run, // Divider enabled
  input wire logic [2:0] clkSel, // Conversion clock select
  input wire logic rcEdge, // Synced RC clock edge
  output logic tadTick // One conversion clock period
);

  logic [6:0] count_reg;
  logic [6:0] divisor;

  assign divisor = div_for(clkSel);

  always_ff @(posedge refClk) begin
    if (!rst_n || !run) begin
      count_reg <= 7'h00;
      tadTick <= 1'b0;
    end else if (is_rc(clkSel)) begin
      count_reg <= 7'h00;
      tadTick <= rcEdge;
    end else if (count_reg == divisor - 7'h01) begin
      count_reg <= 7'h00;
      tadTick <= 1'b1;
    end else begin
      count_reg <= count_reg + 7'h01;
      tadTick <= 1'b0;
    end
  end

endmodule : adcc_clk_div

// ---- adcc_pkg.sv ----
package adcc_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h4;
  localparam logic [3:0] OFS_RES_HI = 4'h8;
  localparam logic [3:0] OFS_RES_LO = 4'hC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CA_ON_BIT = 0;
  localparam int CA_GO_BIT = 1;
  localparam int CA_CHS_LSB = 2;
  localparam int CB_JUST_BIT = 7;
  localparam int CB_CS_LSB = 4;
  localparam int CB_NREF_BIT = 2;
  localparam int CB_PREF_LSB = 0;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'h7F;
  localparam logic [7:0] CTRL_B_MASK = 8'hF7;

  // ****************************************
  // Clock selects and timing
  // ****************************************
  localparam int RES_BITS = 10;
  localparam logic [2:0] CS_RC_A = 3'h3;
  localparam logic [2:0] CS_RC_B = 3'h7;
  localparam int FOSC_PER_INSTR = 4;
  localparam logic [2:0] INSTR_DELAY_CYC = 3'(FOSC_PER_INSTR - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT} adcc_state_t;

  function automatic logic [6:0] div_for(input logic [2:0] sel);
    case (sel)
      3'h0: div_for = 7'h02;
      3'h1: div_for = 7'h08;
      3'h2: div_for = 7'h20;
      3'h4: div_for = 7'h04;
      3'h5: div_for = 7'h10;
      3'h6: div_for = 7'h40;
      default: div_for = 7'h01;
    endcase
  endfunction : div_for

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel == CS_RC_A) || (sel == CS_RC_B);
  endfunction : is_rc

endpackage : adcc_pkg

// ---- adcc_result_fmt.sv ----
module adcc_result_fmt
  import adcc_pkg::*;
(
  input wire logic [9:0] convValue, // Ten-bit result
  input wire logic justRight, // Justify select
  output logic [7:0] hiByte, // Formatted high byte
  output logic [7:0] loByte // Formatted low byte
);

  always_comb begin
    if (justRight) begin
      hiByte = {6'h00, convValue[9:8]};
      loByte = convValue[7:0];
    end else begin
      hiByte = convValue[9:2];
      loByte = {convValue[1:0], 6'h00};
    end
  end

endmodule : adcc_result_fmt

// ---- adcc_top.sv ----
// The address map and the Avalon-MM register port were decided locally.
module adcc_top
  import adcc_pkg::*;
(
  input wire logic ref_clk, // System clock, 10 MHz
  input wire logic rst_n, // Sync reset, active low
  input wire logic [3:0] address, // Avalon byte address
  input wire logic [3:0] byteenable, // Avalon byte enables
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire logic compIn, // Comparator pin, async
  input wire logic rcClkIn, // Dedicated RC clock pin, async
  output logic [9:0] dacTrial, // SAR trial code
  output logic sampleEnable, // Hold cap tracking input
  output logic convOn, // Converter powered
  output logic [4:0] chanSel, // Input channel select
  output logic negRefExt, // Low ref to external pin
  output logic [1:0] posRefSel, // High ref source
  output logic rcClkSelected, // RC clock in use
  output logic doneFlagSet // Pulse: conversion done
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] ctrlA_reg;
  logic [7:0] ctrlB_reg;
  logic [7:0] resHi_reg;
  logic [7:0] resLo_reg;
  adcc_state_t state_reg;
  logic [2:0] delay_reg;
  logic [3:0] bitIdx_reg;
  logic [9:0] sar_reg;
  logic trialPhase_reg;
  logic anyDecided_reg;
  logic lastBit_reg;
  logic rcSel_reg;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic compMeta_reg;
  logic compSync_reg;
  logic rcMeta_reg;
  logic rcSync_reg;
  logic rcPrev_reg;
  logic rcEdge;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      compMeta_reg <= 1'b0;
      compSync_reg <= 1'b0;
    end else begin
      compMeta_reg <= compIn;
      compSync_reg <= compMeta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rcMeta_reg <= 1'b0;
      rcSync_reg <= 1'b0;
      rcPrev_reg <= 1'b0;
    end else begin
      rcMeta_reg <= rcClkIn;
      rcSync_reg <= rcMeta_reg;
      rcPrev_reg <= rcSync_reg;
    end
  end

  assign rcEdge = rcSync_reg && !rcPrev_reg;

  // ****************************************
  // Avalon slave
  // ****************************************
  // One wait cycle: readdata registered, write lands on the release edge
  logic busReq;
  logic busAccept;
  logic wrLane;
  logic [7:0] rdValue;

  assign busReq = read || write;
  assign busAccept = busReq && !waitrequest;
  assign wrLane = write && busAccept && byteenable[0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (busReq && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    case (address)
      OFS_CTRL_A: rdValue = ctrlA_reg & CTRL_A_MASK;
      OFS_CTRL_B: rdValue = ctrlB_reg & CTRL_B_MASK;
      OFS_RES_HI: rdValue = resHi_reg;
      OFS_RES_LO: rdValue = resLo_reg;
      default: rdValue = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, rdValue};
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrResHi;
  logic wrResLo;
  logic goWritten;
  logic onWritten;

  assign wrCtrlA = wrLane && (address == OFS_CTRL_A);
  assign wrCtrlB = wrLane && (address == OFS_CTRL_B);
  assign wrResHi = wrLane && (address == OFS_RES_HI);
  assign wrResLo = wrLane && (address == OFS_RES_LO);
  assign goWritten = writedata[CA_GO_BIT];
  assign onWritten = writedata[CA_ON_BIT];

  // ****************************************
  // Conversion sequencing
  // ****************************************
  logic startReq;
  logic abortReq;
  logic runDiv;
  logic tadTick;
  logic finishNow;
  logic [9:0] partialValue;
  logic [9:0] loadValue;
  logic loadResult;
  logic [7:0] fmtHi;
  logic [7:0] fmtLo;

  // Go set with on set while idle starts; go cleared mid-conversion aborts
  assign startReq = wrCtrlA && goWritten && onWritten && (state_reg == ST_IDLE);
  assign abortReq = wrCtrlA && !goWritten && (state_reg != ST_IDLE);
  assign runDiv = (state_reg == ST_CONVERT);
  assign finishNow = (state_reg == ST_CONVERT) && tadTick && trialPhase_reg
                     && (bitIdx_reg == 4'h0);

  // Unconverted bits copy the last decided one; nothing decided gives zero
  function automatic logic [9:0] fill_partial(input logic [9:0] sar,
                                             input logic [3:0] idx,
                                             input logic fill);
    logic [9:0] v;
    v = sar;
    for (int i = 0; i < RES_BITS; i++) begin
      if (i <= int'(idx)) begin
        v[i] = fill;
      end
    end
    fill_partial = v;
  endfunction : fill_partial

  assign partialValue = fill_partial(sar_reg, bitIdx_reg,
                                     anyDecided_reg && lastBit_reg);
  assign loadValue = finishNow ? {sar_reg[9:1], compSync_reg} : partialValue;
  assign loadResult = finishNow || abortReq;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      delay_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (startReq && is_rc(ctrlB_reg[CB_CS_LSB +: 3])) begin
            state_reg <= ST_DELAY;
            delay_reg <= INSTR_DELAY_CYC;
          end else if (startReq) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_DELAY: begin
          if (abortReq) begin
            state_reg <= ST_IDLE;
          end else if (delay_reg == 3'h0) begin
            state_reg <= ST_CONVERT;
          end else begin
            delay_reg <= delay_reg - 3'h1;
          end
        end
        ST_CONVERT: begin
          if (finishNow || abortReq) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Successive approximation
  // ****************************************
  // Trial bit goes out on one tick, comparator is judged on the next
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sar_reg <= 10'h000;
      bitIdx_reg <= 4'h9;
      trialPhase_reg <= 1'b0;
      anyDecided_reg <= 1'b0;
      lastBit_reg <= 1'b0;
    end else if (startReq) begin
      sar_reg <= 10'h000;
      bitIdx_reg <= 4'h9;
      trialPhase_reg <= 1'b0;
      anyDecided_reg <= 1'b0;
      lastBit_reg <= 1'b0;
    end else if ((state_reg == ST_CONVERT) && tadTick && !abortReq) begin
      if (!trialPhase_reg) begin
        sar_reg[bitIdx_reg] <= 1'b1;
        trialPhase_reg <= 1'b1;
      end else begin
        sar_reg[bitIdx_reg] <= compSync_reg;
        lastBit_reg <= compSync_reg;
        anyDecided_reg <= 1'b1;
        trialPhase_reg <= 1'b0;
        if (bitIdx_reg != 4'h0) begin
          bitIdx_reg <= bitIdx_reg - 4'h1;
        end
      end
    end
  end

  adcc_clk_div u_clk_div (
    .refClk(ref_clk),
    .rst_n(rst_n),
    .run(runDiv),
    .clkSel(ctrlB_reg[CB_CS_LSB +: 3]),
    .rcEdge(rcEdge),
    .tadTick(tadTick)
  );

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrlB_reg <= CTRL_B_RESET;
      rcSel_reg <= 1'b0;
    end else if (wrCtrlB) begin
      ctrlB_reg <= writedata[7:0] & CTRL_B_MASK;
      // Decoded at the write so the pin comes from a flop
      rcSel_reg <= is_rc(writedata[CB_CS_LSB +: 3]);
    end
  end

  // Hardware clearing go wins over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrlA_reg <= CTRL_A_RESET;
    end else if (loadResult) begin
      ctrlA_reg[CA_GO_BIT] <= 1'b0;
      if (wrCtrlA) begin
        ctrlA_reg[CA_ON_BIT] <= onWritten;
        ctrlA_reg[CA_CHS_LSB +: 5] <= writedata[CA_CHS_LSB +: 5];
      end
    end else if (wrCtrlA) begin
      ctrlA_reg[CA_ON_BIT] <= onWritten;
      ctrlA_reg[CA_CHS_LSB +: 5] <= writedata[CA_CHS_LSB +: 5];
      if (state_reg == ST_IDLE) begin
        ctrlA_reg[CA_GO_BIT] <= startReq;
      end
    end
  end

  // ****************************************
  // Result bytes
  // ****************************************
  // Not reset: data survive a reset, as software may still read them
  adcc_result_fmt u_fmt (
    .convValue(loadValue),
    .justRight(ctrlB_reg[CB_JUST_BIT]),
    .hiByte(fmtHi),
    .loByte(fmtLo)
  );

  always_ff @(posedge ref_clk) begin
    if (loadResult) begin
      resHi_reg <= fmtHi;
      resLo_reg <= fmtLo;
    end else begin
      if (wrResHi) begin
        resHi_reg <= writedata[7:0];
      end
      if (wrResLo) begin
        resLo_reg <= writedata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      doneFlagSet <= 1'b0;
    end else begin
      doneFlagSet <= finishNow;
    end
  end

  // ****************************************
  // Analog side drives
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dacTrial <= 10'h000;
      sampleEnable <= 1'b0;
    end else begin
      dacTrial <= sar_reg;
      // Tracking while idle covers the acquisition wait software must allow
      sampleEnable <= ctrlA_reg[CA_ON_BIT] && (state_reg == ST_IDLE);
    end
  end

  assign convOn = ctrlA_reg[CA_ON_BIT];
  assign chanSel = ctrlA_reg[CA_CHS_LSB +: 5];
  assign negRefExt = ctrlB_reg[CB_NREF_BIT];
  assign posRefSel = ctrlB_reg[CB_PREF_LSB +: 2];
  assign rcClkSelected = rcSel_reg;

endmodule : adcc_top

// ---- adcc_top_sva.sv ----
module adcc_top_chk
  import adcc_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic [3:0] address, // Bus address
  input wire logic [3:0] byteenable, // Byte lanes
  input wire logic read, // Bus read
  input wire logic write, // Bus write
  input wire logic [31:0] writedata, // Write data
  input wire logic waitrequest, // Bus wait
  input wire logic sampleEnable, // Tracking
  input wire logic negRefExt, // Low ref
  input wire logic [1:0] posRefSel, // High ref
  input wire logic rcClkSelected, // RC clock
  input wire logic doneFlagSet // Done pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic ctrlBWr;
  assign ctrlBWr = write && !waitrequest && address == OFS_CTRL_B && byteenable[0];
  // ****************************************
  // Checks
  // ****************************************
  AST_WAIT_ONE: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("wait low longer than one cycle");
  AST_WAIT_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait");
  AST_NREF: assert property (ctrlBWr |=> negRefExt == $past(writedata[2]))
    else $error("low reference select wrong");
  AST_PREF: assert property (ctrlBWr |=> posRefSel == $past(writedata[1:0]))
    else $error("high reference select wrong");
  AST_RC_DECODE: assert property (ctrlBWr |=> rcClkSelected == ($past(writedata[5:4]) == 2'h3))
    else $error("RC clock decode wrong");
  AST_DONE_PULSE: assert property (doneFlagSet |=> !doneFlagSet)
    else $error("done pulse too long");
  AST_CTRL_RESET: assert property ($rose(rst_n) |-> !negRefExt && posRefSel == 2'h0 && !rcClkSelected)
    else $error("control not cleared by reset");
  AST_HOLD_OFF: assert property (doneFlagSet |-> !$past(sampleEnable, 2))
    else $error("tracking during conversion");
  COV_DONE: cover property (doneFlagSet);
  COV_RC_DONE: cover property (rcClkSelected && doneFlagSet);
  COV_PREF_FVR: cover property (ctrlBWr ##1 posRefSel == 2'h3);
endmodule : adcc_top_chk
bind adcc_top adcc_top_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
  .byteenable(byteenable), .read(read), .write(write), .writedata(writedata),
  .waitrequest(waitrequest), .sampleEnable(sampleEnable), .negRefExt(negRefExt),
  .posRefSel(posRefSel), .rcClkSelected(rcClkSelected), .doneFlagSet(doneFlagSet));

// ---- tb.sv ----
module tb
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
  logic ref_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, rcClkIn = 1'b0;
  logic [3:0] address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, negRefExt, rcClkSelected, doneFlagSet, sampleEnable, compIn, convOn;
  logic [4:0] chanSel;
  logic [9:0] dacTrial, target = 10'h000;
  logic [1:0] posRefSel;
  logic [7:0] q, w;
  logic [15:0] last;
  int n_mismatch = 0, samples_checked = 0, nDone = 0, n0;
  // Cycles per conversion tick; RC codes use the bench's RC period
  int divs[8] = '{2, 8, 32, 16, 4, 16, 64, 16};
  // Ideal comparator, no lag of its own
  assign compIn = target >= dacTrial;
  always #50 ref_clk = ~ref_clk;
  initial #37 forever #800 rcClkIn = ~rcClkIn;
  always @(posedge ref_clk) if (doneFlagSet === 1'b1) nDone++;
  adcc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
    .byteenable(byteenable), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .compIn(compIn), .rcClkIn(rcClkIn),
    .dacTrial(dacTrial), .sampleEnable(sampleEnable), .convOn(convOn), .chanSel(chanSel),
    .negRefExt(negRefExt), .posRefSel(posRefSel), .rcClkSelected(rcClkSelected),
    .doneFlagSet(doneFlagSet));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done;
    $display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic guard(input logic hit);
    if (hit) begin
      n_mismatch++;
      test_done();
    end
  endtask : guard
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    guard(waitrequest !== 1'b0);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  function automatic logic [15:0] fmt(input logic just, input logic [9:0] v);
    return just ? {6'h00, v} : {v, 6'h00};
  endfunction : fmt
  task automatic chk_res(input logic [15:0] e);
    bus(1'b0, OFS_RES_HI, 8'h00);
    `CHK(q, e[15:8])
    bus(1'b0, OFS_RES_LO, 8'h00);
    `CHK(q, e[7:0])
  endtask : chk_res
  task automatic conv(input logic [2:0] sel, input logic just, input logic [9:0] v);
    int n;
    target <= v;
    bus(1'b1, OFS_CTRL_B, {just, sel, 4'h0});
    bus(1'b1, OFS_CTRL_A, 8'h01);
    repeat (10) @(posedge ref_clk);
    bus(1'b1, OFS_CTRL_A, 8'h03);
    n = 0;
    while (doneFlagSet !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    guard(n >= 5000);
    `CHK(n >= 19 * divs[sel] && n <= 20 * divs[sel] + 12, 1'b1)
    bus(1'b0, OFS_CTRL_A, 8'h00);
    `CHK(q, 8'h01)
    last = fmt(just, v);
    // Divide-by-2 outruns the comparator synchroniser, so its value is not judged
    if (sel != 3'h0) chk_res(last);
  endtask : conv
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hA18D));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_CTRL_B, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b1, OFS_CTRL_B, 8'hFF);
    bus(1'b0, OFS_CTRL_B, 8'h00);
    `CHK(q, 8'hF7)
    bus(1'b0, 4'h2, 8'h00);
    `CHK(q, 8'h00)
    for (int i = 0; i < 8; i++) begin
      w = {1'b0, 3'($urandom), 1'b0, 3'(i)};
      bus(1'b1, OFS_CTRL_B, w);
      @(negedge ref_clk);
      `CHK(negRefExt, w[2])
      `CHK(posRefSel, w[1:0])
      `CHK(rcClkSelected, w[5:4] == 2'h3)
    end
    // Control A fields reach the pins; bit 7 is not stored
    bus(1'b1, OFS_CTRL_A, 8'hFD);
    @(negedge ref_clk);
    `CHK({convOn, chanSel}, 6'h3F)
    @(negedge ref_clk);
    `CHK(sampleEnable, 1'b1)
    // A write without lane 0 must leave the register alone
    @(posedge ref_clk);
    byteenable <= 4'hE;
    bus(1'b1, OFS_CTRL_A, 8'h00);
    byteenable <= 4'hF;
    bus(1'b0, OFS_CTRL_A, 8'h00);
    `CHK(q, 8'h7D)
    `CHK(readdata[31:8], 24'h000000)
    for (int i = 0; i < 8; i++)
      conv(3'(i), i[0], i == 1 ? 10'h000 : i == 6 ? 10'h3FF : 10'($urandom));
    bus(1'b1, OFS_CTRL_B, 8'h10);
    chk_res(last);
    n0 = nDone;
    target <= 10'h3FF;
    bus(1'b1, OFS_CTRL_B, 8'h20);
    bus(1'b1, OFS_CTRL_A, 8'h03);
    repeat (100) @(posedge ref_clk);
    bus(1'b0, OFS_CTRL_A, 8'h00);
    `CHK(q, 8'h03)
    repeat (100) @(posedge ref_clk);
    bus(1'b1, OFS_CTRL_A, 8'h01);
    repeat (40) @(posedge ref_clk);
    `CHK(nDone, n0)
    chk_res(16'hFFC0);
    bus(1'b1, OFS_CTRL_B, 8'hF7);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_CTRL_B, 8'h00);
    `CHK(q, 8'h00)
    `CHK({negRefExt, posRefSel, rcClkSelected}, 4'h0)
    bus(1'b0, OFS_CTRL_A, 8'h00);
    `CHK(q, 8'h00)
    chk_res(16'hFFC0);
    bus(1'b1, OFS_RES_HI, 8'h5A);
    bus(1'b0, OFS_RES_HI, 8'h00);
    `CHK(q, 8'h5A)
    test_done();
  end
endmodule : tb
